// file: core/status_event_summary_hierarchy.sv
`timescale 1ns/1ps
// How it works
// - Falling edge sets event if falling filter set.
// - Falling filter freely written, reads leave it.
// - Filters choose none, rising, falling or both.
// - Only filtered edges set events; held until read.
// - Event latch read-only, cleared by reading it.
// - Summary is OR of events AND enables.
// - Enable mask freely written, reads leave it.
// - Summary feeds a condition bit one level up.
// - Summaries computed continuously through every level.
// - Standard mask acts as standard latch enable.
// - Status bit 6 is master summary of others.
// - Status byte returned by query or serial poll.
// - Service mask bit 6 is ignored.
// - Enabled status bit rising raises service request.
// - Service mask written and read back by commands.
// - Status bit 2 flags non-empty error queue.
// - Status bit 3 is questionable register summary.
// - Status bit 4 flags waiting output message.
// - Status bit 5 is standard event summary.
// - Status bit 7 is operation register summary.
// - Five 16-bit parts, bit 15 always zero.
// - Rising edge sets event if rising filter set.
// - Condition part read-only, driven by hardware.
module status_event_summary_hierarchy #(
	parameter int unsigned WIDTH = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Hardware status feeding the detailed registers.
	input wire logic [WIDTH-1:0] oper_cond,
	input wire logic [WIDTH-1:0] ques_cond,
	// One-cycle pulses that set standard event bits.
	input wire logic [status_pkg::BYTE_W-1:0] std_event_set,
	// Levels feeding the status byte directly.
	input wire logic error_queue_not_empty,
	input wire logic message_waiting_flag,
	input wire logic [1:0] user_status,
	// Command port from the remote message handler.
	input wire logic cmd_valid,
	input wire status_pkg::cmd_t cmd_code,
	input wire logic [0:0] cmd_sel,
	input wire logic [WIDTH-1:0] cmd_wdata,
	// Answer to each command, one cycle later.
	output logic rsp_valid,
	output logic [WIDTH-1:0] rsp_data,
	// Status towards the bus.
	output logic [status_pkg::BYTE_W-1:0] status_byte,
	output logic master_summary_flag,
	output logic srq
);
	import status_pkg::*;

	generate
		if (WIDTH < 9 || WIDTH > REG_W) begin : g_bad_width
			$error("status_event_summary_hierarchy: WIDTH must be 9 to 16");
		end
	endgenerate

	// Returns one when a command of the given code is present.
	function automatic logic is_cmd(input logic valid, input cmd_t code, input cmd_t want);
		is_cmd = valid && (code == want);
	endfunction : is_cmd

	// Widens a byte to the answer width.
	function automatic logic [WIDTH-1:0] widen(input logic [BYTE_W-1:0] b);
		widen = {{(WIDTH-BYTE_W){1'b0}}, b};
	endfunction : widen

	// Chooses the operation or the questionable copy of one register part.
	function automatic logic [WIDTH-1:0] pick_part(input logic use_oper,
		input logic [WIDTH-1:0] oper_part, input logic [WIDTH-1:0] ques_part);
		pick_part = use_oper ? oper_part : ques_part;
	endfunction : pick_part

	logic oper_hit;
	logic ques_hit;
	logic rise_wr;
	logic fall_wr;
	logic enable_wr;
	logic event_rd;
	logic [WIDTH-1:0] oper_cond_q;
	logic [WIDTH-1:0] oper_rise_q;
	logic [WIDTH-1:0] oper_fall_q;
	logic [WIDTH-1:0] oper_enable_q;
	logic [WIDTH-1:0] oper_event_q;
	logic oper_summary;
	logic [WIDTH-1:0] ques_cond_q;
	logic [WIDTH-1:0] ques_rise_q;
	logic [WIDTH-1:0] ques_fall_q;
	logic [WIDTH-1:0] ques_enable_q;
	logic [WIDTH-1:0] ques_event_q;
	logic ques_summary;
	logic [BYTE_W-1:0] std_latch_q;
	logic [BYTE_W-1:0] std_mask_q;
	logic standard_event_summary;
	logic [BYTE_W-1:0] srm_q;
	logic [BYTE_W-1:0] srm_eff;
	logic [BYTE_W-1:0] sb_cond;
	logic [BYTE_W-1:0] sb_full;
	logic master_d;
	logic [BYTE_W-1:0] armed_q;
	logic srq_rise;
	logic poll;
	logic [WIDTH-1:0] rsp_d;

	// Decode of writes and reads aimed at the detailed registers.
	assign rise_wr = is_cmd(cmd_valid, cmd_code, CMD_WRITE_RISE);
	assign fall_wr = is_cmd(cmd_valid, cmd_code, CMD_WRITE_FALL);
	assign enable_wr = is_cmd(cmd_valid, cmd_code, CMD_WRITE_ENABLE);
	assign event_rd = is_cmd(cmd_valid, cmd_code, CMD_READ_EVENT);
	assign oper_hit = (cmd_sel == SEL_OPER);
	assign ques_hit = (cmd_sel == SEL_QUES);

	// Operation register, fed straight from hardware status.
	transition_status_register #(
		.WIDTH(WIDTH)
	) u_oper (
		.clk(clk),
		.reset(reset),
		.cond_in(oper_cond),
		.wr_data(cmd_wdata),
		.rise_wr(rise_wr && oper_hit),
		.fall_wr(fall_wr && oper_hit),
		.enable_wr(enable_wr && oper_hit),
		.event_rd(event_rd && oper_hit),
		.cond_q(oper_cond_q),
		.rise_q(oper_rise_q),
		.fall_q(oper_fall_q),
		.enable_q(oper_enable_q),
		.event_q(oper_event_q),
		.summary(oper_summary)
	);

	// Questionable register, fed straight from hardware status.
	transition_status_register #(
		.WIDTH(WIDTH)
	) u_ques (
		.clk(clk),
		.reset(reset),
		.cond_in(ques_cond),
		.wr_data(cmd_wdata),
		.rise_wr(rise_wr && ques_hit),
		.fall_wr(fall_wr && ques_hit),
		.enable_wr(enable_wr && ques_hit),
		.event_rd(event_rd && ques_hit),
		.cond_q(ques_cond_q),
		.rise_q(ques_rise_q),
		.fall_q(ques_fall_q),
		.enable_q(ques_enable_q),
		.event_q(ques_event_q),
		.summary(ques_summary)
	);

	// Standard event latch: pulses set bits, a read clears, a new pulse wins.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			std_latch_q <= '0;
		end else if (is_cmd(cmd_valid, cmd_code, CMD_READ_STD_EVENT)) begin
			std_latch_q <= std_event_set;
		end else begin
			std_latch_q <= std_latch_q | std_event_set;
		end
	end

	// Standard event mask is the enable part of the standard latch.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			std_mask_q <= STD_MASK_RESET;
		end else if (is_cmd(cmd_valid, cmd_code, CMD_WRITE_STD_MASK)) begin
			std_mask_q <= cmd_wdata[BYTE_W-1:0];
		end
	end

	// Standard summary follows the latch and its mask at all times.
	assign standard_event_summary = |(std_latch_q & std_mask_q);

	// Service request mask, written and read back by its commands.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			srm_q <= SRM_RESET;
		end else if (is_cmd(cmd_valid, cmd_code, CMD_WRITE_SRM)) begin
			srm_q <= cmd_wdata[BYTE_W-1:0];
		end
	end

	// The master bit never takes part in its own computation.
	always_comb begin
		srm_eff = srm_q;
		srm_eff[SB_MASTER] = 1'b0;
	end

	// Status byte condition bits gathered from every lower level.
	always_comb begin
		sb_cond = '0;
		sb_cond[SB_USER0] = user_status[0];
		sb_cond[SB_USER1] = user_status[1];
		sb_cond[SB_ERRQ] = error_queue_not_empty;
		sb_cond[SB_QUES] = ques_summary;
		sb_cond[SB_MSG] = message_waiting_flag;
		sb_cond[SB_STD] = standard_event_summary;
		sb_cond[SB_OPER] = oper_summary;
	end

	// Master summary over all other enabled status bits.
	assign master_d = |(sb_cond & srm_eff);

	always_comb begin
		sb_full = sb_cond;
		sb_full[SB_MASTER] = master_d;
	end

	// Registered copies of the status byte and master flag.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_byte <= '0;
			master_summary_flag <= 1'b0;
		end else begin
			status_byte <= sb_full;
			master_summary_flag <= master_d;
		end
	end

	// Status bits seen last cycle, for rising-edge detection.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			armed_q <= '0;
		end else begin
			armed_q <= sb_cond;
		end
	end

	// Only a bit that rises under its mask raises the request; masking in a set bit does not.
	assign srq_rise = |(sb_cond & ~armed_q & srm_eff);
	assign poll = is_cmd(cmd_valid, cmd_code, CMD_SERIAL_POLL);

	// Request stands until a serial poll; a new rise in that cycle wins.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			srq <= 1'b0;
		end else if (srq_rise) begin
			srq <= 1'b1;
		end else if (poll) begin
			srq <= 1'b0;
		end
	end

	// Answer data chosen by the command; reads never disturb masks.
	always_comb begin
		rsp_d = '0;
		if (cmd_valid) begin
			unique case (cmd_code)
				CMD_READ_STATUS, CMD_SERIAL_POLL: rsp_d = widen(sb_full);
				CMD_READ_SRM: rsp_d = widen(srm_q);
				CMD_READ_STD_EVENT: rsp_d = widen(std_latch_q);
				CMD_READ_STD_MASK: rsp_d = widen(std_mask_q);
				CMD_READ_COND: rsp_d = pick_part(oper_hit, oper_cond_q, ques_cond_q);
				CMD_READ_EVENT: rsp_d = pick_part(oper_hit, oper_event_q, ques_event_q);
				CMD_READ_RISE: rsp_d = pick_part(oper_hit, oper_rise_q, ques_rise_q);
				CMD_READ_FALL: rsp_d = pick_part(oper_hit, oper_fall_q, ques_fall_q);
				CMD_READ_ENABLE: rsp_d = pick_part(oper_hit, oper_enable_q, ques_enable_q);
				default: rsp_d = '0;
			endcase
		end
	end

	// Every command is answered one cycle after it is taken.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp_data <= '0;
		end else begin
			rsp_valid <= cmd_valid;
			rsp_data <= rsp_d;
		end
	end
endmodule : status_event_summary_hierarchy

// file: core/status_pkg.sv
package status_pkg;
	// Widths of the two register families.
	localparam int unsigned REG_W = 16;
	localparam int unsigned BYTE_W = 8;
	// Bit positions inside the status byte.
	localparam int unsigned SB_USER0 = 0;
	localparam int unsigned SB_USER1 = 1;
	localparam int unsigned SB_ERRQ = 2;
	localparam int unsigned SB_QUES = 3;
	localparam int unsigned SB_MSG = 4;
	localparam int unsigned SB_STD = 5;
	localparam int unsigned SB_MASTER = 6;
	localparam int unsigned SB_OPER = 7;
	// Reset values of the writable parts.
	localparam logic [REG_W-1:0] RISE_RESET = 16'h7fff;
	localparam logic [REG_W-1:0] FALL_RESET = 16'h0000;
	localparam logic [REG_W-1:0] ENABLE_RESET = 16'h0000;
	localparam logic [BYTE_W-1:0] SRM_RESET = 8'h00;
	localparam logic [BYTE_W-1:0] STD_MASK_RESET = 8'h00;
	// Selector of the detailed register addressed by a command.
	localparam logic [0:0] SEL_OPER = 1'h0;
	localparam logic [0:0] SEL_QUES = 1'h1;
	// Commands accepted on the command port.
	typedef enum logic [3:0] {
		CMD_READ_STATUS,
		CMD_SERIAL_POLL,
		CMD_WRITE_SRM,
		CMD_READ_SRM,
		CMD_READ_STD_EVENT,
		CMD_WRITE_STD_MASK,
		CMD_READ_STD_MASK,
		CMD_READ_COND,
		CMD_READ_EVENT,
		CMD_WRITE_RISE,
		CMD_READ_RISE,
		CMD_WRITE_FALL,
		CMD_READ_FALL,
		CMD_WRITE_ENABLE,
		CMD_READ_ENABLE
	} cmd_t;
endpackage : status_pkg

// file: core/transition_status_register.sv
`timescale 1ns/1ps
module transition_status_register #(
	parameter int unsigned WIDTH = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Live status from hardware or a lower summary.
	input wire logic [WIDTH-1:0] cond_in,
	// Writes and reads from the command decoder.
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rise_wr,
	input wire logic fall_wr,
	input wire logic enable_wr,
	input wire logic event_rd,
	// Contents of the five parts and the summary.
	output logic [WIDTH-1:0] cond_q,
	output logic [WIDTH-1:0] rise_q,
	output logic [WIDTH-1:0] fall_q,
	output logic [WIDTH-1:0] enable_q,
	output logic [WIDTH-1:0] event_q,
	output logic summary
);
	import status_pkg::*;

	// The top bit of every part is held at zero.
	localparam logic [WIDTH-1:0] USED = {1'b0, {(WIDTH-1){1'b1}}};

	generate
		if (WIDTH < 2 || WIDTH > REG_W) begin : g_bad_width
			$error("transition_status_register: WIDTH must be 2 to 16");
		end
	endgenerate

	logic [WIDTH-1:0] edge_set;

	// Condition part follows the live inputs; it is never written.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cond_q <= '0;
		end else begin
			cond_q <= cond_in & USED;
		end
	end

	// Edge filters keep their value over reads.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rise_q <= RISE_RESET[WIDTH-1:0] & USED;
			fall_q <= FALL_RESET[WIDTH-1:0] & USED;
		end else begin
			if (rise_wr) begin
				rise_q <= wr_data & USED;
			end
			if (fall_wr) begin
				fall_q <= wr_data & USED;
			end
		end
	end

	// Enable mask is written at will and unchanged by reads.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			enable_q <= ENABLE_RESET[WIDTH-1:0] & USED;
		end else if (enable_wr) begin
			enable_q <= wr_data & USED;
		end
	end

	// Rising edges pass the rising filter, falling edges the falling one.
	assign edge_set = ((cond_in & ~cond_q & rise_q)
		| (~cond_in & cond_q & fall_q)) & USED;

	// Event latch holds until read; a read clears it but a new edge wins.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			event_q <= '0;
		end else begin
			event_q <= (event_rd ? '0 : event_q) | edge_set;
		end
	end

	// Summary is the OR of enabled events.
	assign summary = |(event_q & enable_q);
endmodule : transition_status_register

// file: tb/bus_controller_model.sv
`timescale 1ns/1ps
// Remote controller that sends one command and takes its answer.
module bus_controller_model (
	// Clock.
	input wire logic clk,
	// Command port.
	output logic cmd_valid,
	output status_pkg::cmd_t cmd_code,
	output logic [0:0] cmd_sel,
	output logic [15:0] cmd_wdata,
	// Answer.
	input wire logic [15:0] rsp_data
);
	import status_pkg::*;
	// Idle until the first command.
	initial begin
		cmd_valid = 1'b0;
		cmd_code = CMD_READ_STATUS;
		cmd_sel = 1'h0;
		cmd_wdata = 16'h0000;
	end
	// Holds a command for one edge, takes the answer just after that edge, then waits one more edge.
	task automatic issue(input cmd_t c, input logic [0:0] s, input logic [15:0] w,
		output logic [15:0] r);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_sel <= s;
		cmd_wdata <= w;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_sel <= ~s;
		cmd_wdata <= ~w;
		#1 r = rsp_data;
		@(posedge clk);
	endtask : issue
endmodule : bus_controller_model

// file: tb/status_event_summary_hierarchy_props.sv
`timescale 1ns/1ps
// Watches the status hierarchy at its ports.
module status_hierarchy_props #(
	parameter int unsigned WIDTH = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Inputs that shape the answers.
	input wire logic error_queue_not_empty,
	input wire logic message_waiting_flag,
	input wire logic cmd_valid,
	input wire status_pkg::cmd_t cmd_code,
	input wire logic [WIDTH-1:0] cmd_wdata,
	// Outputs under watch.
	input wire logic rsp_valid,
	input wire logic [WIDTH-1:0] rsp_data,
	input wire logic [status_pkg::BYTE_W-1:0] status_byte,
	input wire logic master_summary_flag,
	input wire logic srq
);
	import status_pkg::*;
	logic [7:0] srm_q, srm_prev_q, sb_prev_q;
	logic rise_en, poll;
	// Mirrors the service mask and keeps the mask and byte one edge back.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			srm_q <= SRM_RESET;
			srm_prev_q <= SRM_RESET;
			sb_prev_q <= 8'h00;
		end else begin
			if (cmd_valid && cmd_code == CMD_WRITE_SRM) begin
				srm_q <= cmd_wdata[7:0];
			end
			srm_prev_q <= srm_q;
			sb_prev_q <= status_byte;
		end
	end
	// A masked bit other than the master bit has just risen.
	assign rise_en = |(status_byte & ~sb_prev_q & srm_prev_q & 8'hbf);
	assign poll = cmd_valid && cmd_code == CMD_SERIAL_POLL;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	master_flag_a: assert property (master_summary_flag == status_byte[6])
		else $error("master flag differs from bit 6");
	master_sum_a: assert property (status_byte[6] == |(status_byte & srm_prev_q & 8'hbf))
		else $error("master bit wrong");
	direct_bits_a: assert property (!$past(reset) |-> status_byte[4] == $past(message_waiting_flag)
		&& status_byte[2] == $past(error_queue_not_empty))
		else $error("direct status bits wrong");
	srq_rise_a: assert property (rise_en |-> srq)
		else $error("request missing");
	srq_cause_a: assert property ($rose(srq) |-> rise_en)
		else $error("request without cause");
	srq_hold_a: assert property ($fell(srq) |-> $past(poll))
		else $error("request dropped without poll");
	rsp_time_a: assert property (!$past(reset) |-> rsp_valid == $past(cmd_valid))
		else $error("answer timing wrong");
	stb_reply_a: assert property (cmd_valid && cmd_code inside {CMD_READ_STATUS, CMD_SERIAL_POLL}
		|=> rsp_data == WIDTH'(status_byte))
		else $error("status reply wrong");
	mask_reply_a: assert property (cmd_valid && cmd_code == CMD_READ_SRM
		|=> rsp_data == WIDTH'($past(srm_q)))
		else $error("mask reply wrong");
	top_bit_a: assert property (rsp_data[WIDTH-1] == 1'b0)
		else $error("top bit set");
endmodule : status_hierarchy_props

bind status_event_summary_hierarchy status_hierarchy_props #(.WIDTH(WIDTH)) props (
	.clk(clk), .reset(reset), .error_queue_not_empty(error_queue_not_empty),
	.message_waiting_flag(message_waiting_flag), .cmd_valid(cmd_valid),
	.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
	.status_byte(status_byte), .master_summary_flag(master_summary_flag), .srq(srq)
);

// file: tb/status_event_summary_hierarchy_tb.sv
`timescale 1ns/1ps
// Drives the status hierarchy through the controller model.
module status_event_summary_hierarchy_tb;
	import status_pkg::*;
	typedef struct {cmd_t c; logic [0:0] s; logic [15:0] w; logic [15:0] e;} row_t;
	logic clk, reset, error_queue_not_empty, message_waiting_flag, cmd_valid;
	logic rsp_valid, master_summary_flag, srq;
	logic [15:0] oper_cond, ques_cond, cmd_wdata, rsp_data;
	logic [7:0] std_event_set, status_byte;
	logic [1:0] user_status;
	logic [0:0] cmd_sel;
	cmd_t cmd_code;
	int error_cnt = 0;
	int n_tests = 0;
	row_t rows [16] = '{
		'{CMD_READ_RISE, 1'h0, 16'h0, 16'h7fff}, '{CMD_READ_FALL, 1'h0, 16'h0, 16'h0},
		'{CMD_READ_ENABLE, 1'h1, 16'h0, 16'h0}, '{CMD_READ_SRM, 1'h0, 16'h0, 16'h0},
		'{CMD_READ_STD_MASK, 1'h0, 16'h0, 16'h0}, '{CMD_WRITE_FALL, 1'h1, 16'hffff, 16'h0},
		'{CMD_READ_FALL, 1'h1, 16'h0, 16'h7fff}, '{CMD_READ_FALL, 1'h1, 16'h0, 16'h7fff},
		'{CMD_WRITE_ENABLE, 1'h0, 16'h1234, 16'h0}, '{CMD_READ_ENABLE, 1'h0, 16'h0, 16'h1234},
		'{CMD_READ_ENABLE, 1'h0, 16'h0, 16'h1234}, '{CMD_WRITE_SRM, 1'h0, 16'h00c4, 16'h0},
		'{CMD_READ_SRM, 1'h0, 16'h0, 16'h00c4}, '{CMD_WRITE_STD_MASK, 1'h0, 16'h005a, 16'h0},
		'{CMD_READ_STD_MASK, 1'h0, 16'h0, 16'h005a}, '{CMD_WRITE_RISE, 1'h0, 16'h8001, 16'h0}};
	status_event_summary_hierarchy #(.WIDTH(16)) uut (
		.clk(clk), .reset(reset), .oper_cond(oper_cond), .ques_cond(ques_cond),
		.std_event_set(std_event_set), .error_queue_not_empty(error_queue_not_empty),
		.message_waiting_flag(message_waiting_flag), .user_status(user_status),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .status_byte(status_byte),
		.master_summary_flag(master_summary_flag), .srq(srq));
	bus_controller_model ctl (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_data(rsp_data));
	// Compares one value and reports a difference.
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	// Sends one command and compares its answer.
	task automatic cmd(input cmd_t c, input logic [0:0] s, input logic [15:0] w,
		input logic [15:0] e);
		logic [15:0] r;
		ctl.issue(c, s, w, r);
		check(r, e);
	endtask : cmd
	// Compares the settled status byte and request, then waits an edge.
	task automatic sb_is(input logic [7:0] e, input logic q);
		#1;
		check({8'h00, status_byte}, {8'h00, e});
		check({15'h0000, srq}, {15'h0000, q});
		@(posedge clk);
	endtask : sb_is
	// Prints the counts and the verdict.
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Cuts a hung run short.
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	// Main sequence.
	initial begin
		reset = 1'b1;
		oper_cond = 16'h0000;
		ques_cond = 16'h0000;
		std_event_set = 8'h00;
		error_queue_not_empty = 1'b0;
		message_waiting_flag = 1'b0;
		user_status = 2'h0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			cmd(rows[i].c, rows[i].s, rows[i].w, rows[i].e);
		end
		// Each filter mode on one bit, with reads landing on the edge itself.
		for (int m = 0; m < 4; m++) begin
			cmd(CMD_WRITE_RISE, 1'h0, 16'(m % 2), 16'h0000);
			cmd(CMD_WRITE_FALL, 1'h0, 16'(m / 2), 16'h0000);
			oper_cond <= 16'h0001;
			cmd(CMD_READ_EVENT, 1'h0, 16'h0000, 16'h0000);
			cmd(CMD_READ_EVENT, 1'h0, 16'h0000, 16'(m % 2));
			oper_cond <= 16'h0000;
			cmd(CMD_READ_EVENT, 1'h0, 16'h0000, 16'h0000);
			cmd(CMD_READ_EVENT, 1'h0, 16'h0000, 16'(m / 2));
		end
		cmd(CMD_WRITE_SRM, 1'h0, 16'h0088, 16'h0000);
		// A masked event climbs to its status bit, the master bit and the request.
		for (int s = 0; s < 2; s++) begin
			logic [7:0] sb;
			sb = s ? 8'h48 : 8'hc0;
			cmd(CMD_WRITE_RISE, 1'(s), 16'h0002, 16'h0000);
			cmd(CMD_WRITE_FALL, 1'(s), 16'h0000, 16'h0000);
			cmd(CMD_WRITE_ENABLE, 1'(s), 16'h0000, 16'h0000);
			{ques_cond, oper_cond} <= s ? 32'h0002_0000 : 32'h0000_0002;
			repeat (2) @(posedge clk);
			sb_is(8'h00, 1'b0);
			cmd(CMD_READ_COND, 1'(s), 16'h0000, 16'h0002);
			cmd(CMD_WRITE_ENABLE, 1'(s), 16'h0002, 16'h0000);
			sb_is(sb, 1'b1);
			cmd(CMD_READ_STATUS, 1'h0, 16'h0000, {8'h00, sb});
			sb_is(sb, 1'b1);
			cmd(CMD_SERIAL_POLL, 1'h0, 16'h0000, {8'h00, sb});
			sb_is(sb, 1'b0);
			cmd(CMD_READ_EVENT, 1'(s), 16'h0000, 16'h0002);
			sb_is(8'h00, 1'b0);
		end
		// Mask bit 6 alone leaves the master bit clear.
		cmd(CMD_WRITE_SRM, 1'h0, 16'h0040, 16'h0000);
		error_queue_not_empty <= 1'b1;
		message_waiting_flag <= 1'b1;
		user_status <= 2'h3;
		@(posedge clk);
		sb_is(8'h17, 1'b0);
		// Enabling a bit that is already set gives the master bit but no request.
		cmd(CMD_WRITE_SRM, 1'h0, 16'h0010, 16'h0000);
		sb_is(8'h57, 1'b0);
		error_queue_not_empty <= 1'b0;
		message_waiting_flag <= 1'b0;
		user_status <= 2'h0;
		// With the error bit enabled a new error raises a request.
		cmd(CMD_WRITE_SRM, 1'h0, 16'h0004, 16'h0000);
		error_queue_not_empty <= 1'b1;
		@(posedge clk);
		sb_is(8'h44, 1'b1);
		cmd(CMD_SERIAL_POLL, 1'h0, 16'h0000, 16'h0044);
		error_queue_not_empty <= 1'b0;
		// Standard events count only where their mask bit is set.
		std_event_set <= 8'h01;
		@(posedge clk);
		std_event_set <= 8'h00;
		@(posedge clk);
		sb_is(8'h00, 1'b0);
		std_event_set <= 8'h02;
		@(posedge clk);
		std_event_set <= 8'h00;
		@(posedge clk);
		sb_is(8'h20, 1'b0);
		// A standard event landing on the clearing read survives it.
		std_event_set <= 8'h08;
		cmd(CMD_READ_STD_EVENT, 1'h0, 16'h0000, 16'h0003);
		std_event_set <= 8'h00;
		cmd(CMD_READ_STD_EVENT, 1'h0, 16'h0000, 16'h0008);
		oper_cond <= 16'hffff;
		@(posedge clk);
		cmd(CMD_READ_COND, 1'h0, 16'h0000, 16'h7fff);
		// A second reset restores the stored parts.
		reset <= 1'b1;
		@(posedge clk);
		sb_is(8'h00, 1'b0);
		reset <= 1'b0;
		cmd(CMD_READ_RISE, 1'h1, 16'h0000, 16'h7fff);
		cmd(CMD_READ_SRM, 1'h0, 16'h0000, 16'h0000);
		summarize();
	end
endmodule : status_event_summary_hierarchy_tb
